/* include/pw_params.svh */
`ifndef PW_PARAMS_SVH
`define PW_PARAMS_SVH
`define TS_LEN        8'd188
`define TS_NULL_PID   13'h1fff
`define TS_SYNC       8'h47
`define TS_FIRST_FWD  8'd3
`define L2_VERSION    4'h3
`define HDR_BYTES     4'd12
`define EXT_DATA      2'b00
`define EXT_PROBE     2'b01
`define MAX_TS_DEF    7
`endif

/* include/pw_pkg.sv */
package pw_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_hdr  = 3'b001,
    st_pay  = 3'b011,
    st_chk  = 3'b010,
    st_drop = 3'b110
  } rx_state_e;
  typedef enum logic [1:0] {
    tx_idle = 2'b00,
    tx_hdr  = 2'b01,
    tx_pay  = 2'b11
  } tx_state_e;
endpackage

/* include/pw_link_if.sv */
`timescale 1ns/1ps
interface pw_link_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       first;
  logic       last;
  modport core (output valid, output data, output first, output last, input ready);
  modport node (input valid, input data, input first, input last, output ready);
endinterface // pw_link_if

/* logic/pw_node_rx.sv */
`timescale 1ns/1ps
`include "pw_params.svh"
// Overview of operation
// R1: only transport bit zero is data
// R2: eleven reserved header bits are ignored
// R3: version field must equal three
// R4: sixteen-bit reserved field is ignored
// R5: session identifier must match agreed session
// R6: no cookie; sublayer follows session identifier
// R7: accept sublayer matching negotiated type
// R8: wrong pseudowire type raises teardown indication
// R9: malformed sublayer header packets silently dropped
// R10: payload is whole 188-byte transport packets
// R11: streaming mode segments hold frames or link data
// R12: connectivity bit sent as zero
// R13: sequence number used only when valid
// R14: extended header 00 means active type
// R15: reserved bit and byte ignored
// R16: single flow identifier supported
// R17: sequence increments by one per packet
// R18: sender picks random starting sequence
// R19: one transport session per output channel
// R20: no filler bytes between transport packets
// R21: accept one to seven transport packets
// R22: null packets may be discarded
// R23: extended header 01 is latency probe
// R24: payload length must be multiple of 188
module pw_node_rx
  import pw_pkg::*;
#(
  parameter int MAX_TS = `MAX_TS_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  pw_link_if.node          link,
  input  wire logic [31:0] session_identifier,
  input  wire logic        mpeg_transport_mode,
  input  wire logic        drop_null_en,
  output logic             ts_valid,
  output logic [7:0]       ts_data,
  output logic             ts_first,
  output logic             ts_last,
  output logic             pkt_ok,
  output logic             pkt_drop,
  output logic             session_teardown_message,
  output logic             latency_probe,
  output logic             seq_gap,
  output logic [15:0]      last_seq
);
  rx_state_e   st_q, st_d;
  logic [3:0]  hcnt_q, hcnt_d;
  logic [7:0]  bcnt_q, bcnt_d;
  logic [3:0]  tcnt_q, tcnt_d;
  logic        bad_q, bad_d;
  logic        wrong_q, wrong_d;
  logic        probe_q, probe_d;
  logic        sv_q, sv_d;
  logic [15:0] seq_q, seq_d;
  logic        seqok_q, seqok_d;
  logic [15:0] ls_q, ls_d;
  logic [31:0] sid_q, sid_d;
  logic [12:0] pid_q, pid_d;
  logic        null_q, null_d;
  logic        tv_q, tv_d, tf_q, tf_d, tl_q, tl_d;
  logic [7:0]  td_q, td_d;
  logic        ok_q, ok_d, dr_q, dr_d, td_ev_q, td_ev_d, lp_q, lp_d, gp_q, gp_d;
  logic        beat;

  assign link.ready = 1'b1;
  // node never stalls, so every valid byte is taken
  assign beat = link.valid;

  always_comb begin
    st_d = st_q; hcnt_d = hcnt_q; bcnt_d = bcnt_q; tcnt_d = tcnt_q;
    bad_d = bad_q; wrong_d = wrong_q; probe_d = probe_q; sv_d = sv_q;
    seq_d = seq_q; seqok_d = seqok_q; sid_d = sid_q;
    pid_d = pid_q; null_d = null_q;
    tv_d = 1'b0; tf_d = 1'b0; tl_d = 1'b0; td_d = td_q;
    ok_d = 1'b0; dr_d = 1'b0; td_ev_d = 1'b0; lp_d = 1'b0; gp_d = 1'b0;
    case (st_q)
      st_idle: begin
        if (beat && link.first) begin
          st_d = st_hdr;
          hcnt_d = 4'd1;
          bad_d = link.data[7]; // R1
          wrong_d = 1'b0;
          probe_d = 1'b0;
          sid_d = '0;
          if (link.last) begin
            st_d = st_idle;
            dr_d = 1'b1;
          end
        end
      end
      st_hdr: begin
        if (beat) begin
          hcnt_d = hcnt_q + 4'd1;
          case (hcnt_q)
            4'd1: if (link.data[3:0] != `L2_VERSION) bad_d = 1'b1; // R3 R2
            4'd2, 4'd3: ; // R4
            4'd4, 4'd5, 4'd6, 4'd7: sid_d = {sid_q[23:0], link.data}; // R5 R6
            4'd8: begin
              if (sid_q != session_identifier) bad_d = 1'b1; // R5 R19
              sv_d = link.data[6]; // R13 R12
              if (link.data[5:4] == `EXT_PROBE) probe_d = 1'b1; // R23
              else if (link.data[5:4] != `EXT_DATA) bad_d = 1'b1; // R9 R14
              if (!mpeg_transport_mode) wrong_d = 1'b1; // R8 R7 R11
              if (link.data[2:0] != 3'd0) bad_d = 1'b1; // R16 R15
            end
            4'd9: ; // R15
            4'd10: seq_d[15:8] = link.data;
            default: begin
              seq_d[7:0] = link.data;
              st_d = st_pay;
              bcnt_d = '0;
              tcnt_d = '0;
            end
          endcase
          if (link.last) begin
            st_d = st_idle;
            dr_d = 1'b1;
          end
        end
      end
      st_pay: begin
        if (beat) begin
          if (bcnt_q == 8'd1) pid_d[12:8] = link.data[4:0];
          if (bcnt_q == 8'd2) begin
            pid_d[7:0] = link.data;
            null_d = drop_null_en && ({pid_q[12:8], link.data} == `TS_NULL_PID); // R22
          end
          if (bcnt_q == 8'd0) null_d = 1'b0;
          // the sync and identifier bytes of each segment are never forwarded
          // R10 R20
          tv_d = !bad_q && !wrong_q && !probe_q && !null_q && bcnt_q >= `TS_FIRST_FWD;
          tf_d = tv_d && bcnt_q == `TS_FIRST_FWD;
          td_d = link.data;
          if (bcnt_q == `TS_LEN - 8'd1) begin
            bcnt_d = '0;
            tcnt_d = tcnt_q + 4'd1;
            tl_d = tv_d;
          end else begin
            bcnt_d = bcnt_q + 8'd1;
          end
          if (link.last) begin
            st_d = st_chk;
            if (bcnt_q != `TS_LEN - 8'd1) bad_d = 1'b1; // R24
            if (tcnt_q >= 4'(MAX_TS)) bad_d = 1'b1; // R21
          end
        end
      end
      // outcome ranks: wrong type, probe, malformed, good
      st_chk: begin
        st_d = st_idle;
        if (wrong_q) td_ev_d = 1'b1; // R8
        else if (probe_q) lp_d = 1'b1; // R23
        else if (bad_q) dr_d = 1'b1; // R9
        else begin
          ok_d = 1'b1;
          if (sv_q) begin // R13
            if (seqok_q) gp_d = (seq_q != 16'(ls_q + 16'd1)); // R17
            seqok_d = 1'b1;
          end
        end
      end
      default: st_d = st_idle;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= st_idle; hcnt_q <= '0; bcnt_q <= '0; tcnt_q <= '0;
      bad_q <= 1'b0; wrong_q <= 1'b0; probe_q <= 1'b0; sv_q <= 1'b0;
      seq_q <= '0; seqok_q <= 1'b0; sid_q <= '0;
      pid_q <= '0; null_q <= 1'b0;
      tv_q <= 1'b0; tf_q <= 1'b0; tl_q <= 1'b0; td_q <= '0;
      ok_q <= 1'b0; dr_q <= 1'b0; td_ev_q <= 1'b0; lp_q <= 1'b0; gp_q <= 1'b0;
    end else begin
      st_q <= st_d; hcnt_q <= hcnt_d; bcnt_q <= bcnt_d; tcnt_q <= tcnt_d;
      bad_q <= bad_d; wrong_q <= wrong_d; probe_q <= probe_d; sv_q <= sv_d;
      seq_q <= seq_d; seqok_q <= seqok_d; sid_q <= sid_d;
      pid_q <= pid_d; null_q <= null_d;
      tv_q <= tv_d; tf_q <= tf_d; tl_q <= tl_d; td_q <= td_d;
      ok_q <= ok_d; dr_q <= dr_d; td_ev_q <= td_ev_d; lp_q <= lp_d; gp_q <= gp_d;
    end
  end

  // last delivered sequence number, kept to spot lost packets
  always_comb begin
    ls_d = ls_q;
    if (ok_d && sv_q) ls_d = seq_q; // R13
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) ls_q <= '0;
    else ls_q <= ls_d;
  end

  assign ts_valid = tv_q;
  assign ts_data = td_q;
  assign ts_first = tf_q;
  assign ts_last = tl_q;
  assign pkt_ok = ok_q;
  assign pkt_drop = dr_q;
  assign session_teardown_message = td_ev_q;
  assign latency_probe = lp_q;
  assign seq_gap = gp_q;
  assign last_seq = ls_q;
endmodule // pw_node_rx

/* logic/pw_core_tx.sv */
`timescale 1ns/1ps
`include "pw_params.svh"
module pw_core_tx
  import pw_pkg::*;
#(
  parameter int MAX_TS = `MAX_TS_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  pw_link_if.core          link,
  input  wire logic        start,
  input  wire logic [3:0]  ts_count,
  input  wire logic [31:0] session_identifier,
  input  wire logic [15:0] seq_seed,
  input  wire logic        seq_load,
  input  wire logic        null_sel,
  output logic             busy
);
  tx_state_e   st_q, st_d;
  logic [3:0]  h_q, h_d, n_q, n_d, t_q, t_d;
  logic [7:0]  b_q, b_d;
  logic [15:0] seq_q, seq_d;
  logic [7:0]  hb;
  logic [7:0]  pb;

  always_comb begin
    case (h_q)
      4'd0: hb = 8'h00; // R1 R2
      4'd1: hb = {4'h0, `L2_VERSION}; // R3
      4'd2, 4'd3: hb = 8'h00; // R4
      4'd4: hb = session_identifier[31:24]; // R19
      4'd5: hb = session_identifier[23:16];
      4'd6: hb = session_identifier[15:8];
      4'd7: hb = session_identifier[7:0];
      4'd8: hb = {1'b0, 1'b1, `EXT_DATA, 4'h0}; // R12 R13 R14 R15 R16
      4'd9: hb = 8'h00;
      4'd10: hb = seq_q[15:8];
      default: hb = seq_q[7:0];
    endcase
    case (b_q)
      8'd0: pb = `TS_SYNC;
      8'd1: pb = null_sel ? {3'b000, 5'(`TS_NULL_PID >> 8)} : 8'h00; // R22
      8'd2: pb = null_sel ? 8'(`TS_NULL_PID) : 8'h00;
      default: pb = b_q;
    endcase
  end

  always_comb begin
    st_d = st_q; h_d = h_q; n_d = n_q; t_d = t_q; b_d = b_q; seq_d = seq_q;
    if (seq_load) seq_d = seq_seed; // R18
    case (st_q)
      tx_idle: if (start && ts_count != 4'd0 && ts_count <= 4'(MAX_TS)) begin // R21
        st_d = tx_hdr; h_d = '0; n_d = ts_count; t_d = '0; b_d = '0;
      end
      tx_hdr: if (link.ready) begin
        h_d = h_q + 4'd1;
        if (h_q == `HDR_BYTES - 4'd1) st_d = tx_pay;
      end
      tx_pay: if (link.ready) begin // R10 R20
        if (b_q == `TS_LEN - 8'd1) begin
          b_d = '0;
          t_d = t_q + 4'd1;
          if (t_q == n_q - 4'd1) begin
            st_d = tx_idle;
            seq_d = seq_q + 16'd1; // R17
          end
        end else b_d = b_q + 8'd1;
      end
      default: st_d = tx_idle;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= tx_idle; h_q <= '0; n_q <= '0; t_q <= '0; b_q <= '0; seq_q <= '0;
    end else begin
      st_q <= st_d; h_q <= h_d; n_q <= n_d; t_q <= t_d; b_q <= b_d; seq_q <= seq_d;
    end
  end

  assign link.valid = (st_q != tx_idle);
  assign link.data = (st_q == tx_hdr) ? hb : pb;
  assign link.first = (st_q == tx_hdr) && (h_q == 4'd0);
  assign link.last = (st_q == tx_pay) && (b_q == `TS_LEN - 8'd1) && (t_q == n_q - 4'd1);
  assign busy = (st_q != tx_idle);
endmodule // pw_core_tx

/* testbench/pw_link_sva.sv */
`timescale 1ns/1ps
module pw_link_sva (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       valid,
  input wire logic       ready,
  input wire logic [7:0] data,
  input wire logic       first,
  input wire logic       last
);
  logic [10:0] cnt_q, cnt_d, idx;
  logic [7:0]  hi_q, hi_d;
  logic [15:0] prev_q, prev_d;
  logic        have_q, have_d;
  // byte index within the current packet
  assign idx = first ? 11'h000 : cnt_q;
  always_comb begin
    cnt_d  = valid ? idx + 11'h001 : cnt_q;
    hi_d   = (valid && idx == 11'h00a) ? data : hi_q;
    prev_d = (valid && idx == 11'h00b) ? {hi_q, data} : prev_q;
    have_d = have_q | (valid && idx == 11'h00b);
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= 11'h000;
      hi_q   <= 8'h00;
      prev_q <= 16'h0000;
      have_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      hi_q   <= hi_d;
      prev_q <= prev_d;
      have_q <= have_d;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_lead; valid && first |-> data == 8'h00; endproperty
  a_lead: assert property (p_lead) else $error("first header byte not zero");
  property p_ver; valid && idx == 11'h001 |-> data == 8'h03; endproperty
  a_ver: assert property (p_ver) else $error("version byte wrong");
  property p_res; valid && (idx == 11'h002 || idx == 11'h003) |-> data == 8'h00; endproperty
  a_res: assert property (p_res) else $error("reserved field not zero");
  property p_sub; valid && idx == 11'h008 |-> data[7] == 1'b0 && data[5:3] == 3'h0; endproperty
  a_sub: assert property (p_sub) else $error("sublayer flags wrong");
  property p_flow; valid && idx == 11'h008 |-> data[2:0] == 3'h0; endproperty
  a_flow: assert property (p_flow) else $error("flow not zero");
  property p_rbyte; valid && idx == 11'h009 |-> data == 8'h00; endproperty
  a_rbyte: assert property (p_rbyte) else $error("reserved byte not zero");
  property p_len;
    valid && last |-> idx >= 11'd199 && idx <= 11'd1327 && (idx - 11'd11) % 11'd188 == 11'd0;
  endproperty
  a_len: assert property (p_len) else $error("payload length wrong");
  property p_seq; valid && idx == 11'h00b && have_q |-> {hi_q, data} == prev_q + 16'h0001; endproperty
  a_seq: assert property (p_seq) else $error("sequence not incremented");
  property p_gap; valid && !last |=> valid; endproperty
  a_gap: assert property (p_gap) else $error("gap inside packet");
  property p_rdy; valid |-> ready; endproperty
  a_rdy: assert property (p_rdy) else $error("node stalled the link");
  c_one: cover property (valid && last && idx == 11'd199);
  c_seven: cover property (valid && last && idx == 11'd1327);
  c_seq: cover property (valid && idx == 11'h00b && have_q);
endmodule // pw_link_sva

/* testbench/l2tpv3_mpeg_pw_receiver_test.sv */
`timescale 1ns/1ps
`include "pw_params.svh"
module l2tpv3_mpeg_pw_receiver_test;
  localparam logic [31:0] sid = 32'h5a3c_0f11;
  logic        core_clk = 1'b0, resetn = 1'b0, start = 1'b0, seq_load = 1'b0;
  logic        null_sel = 1'b0, mode = 1'b1, drop_null = 1'b0, busy;
  logic [3:0]  ts_count = 4'h1;
  logic [31:0] tx_id = sid, rng = 32'd47934;
  logic [15:0] seed = 16'h0000, last_seq;
  logic        ts_valid, pkt_ok, pkt_drop, td, bad_drop;
  logic        ts_first, ts_last, gap, bad_probe, lost = 1'b0;
  logic [7:0]  ts_data, exp_byte = `TS_FIRST_FWD;
  int          n_errors = 0, check_count = 0, cycles = 0, nbytes = 0;
  logic [51:0] exp_q[$];
  logic [51:0] e;
  pw_link_if link();
  pw_link_if bad();
  pw_core_tx u_pw_core_tx (.core_clk(core_clk), .resetn(resetn), .link(link), .start(start),
    .ts_count(ts_count), .session_identifier(tx_id), .seq_seed(seed), .seq_load(seq_load),
    .null_sel(null_sel), .busy(busy));
  pw_node_rx u_pw_node_rx (.core_clk(core_clk), .resetn(resetn), .link(link), .session_identifier(sid),
    .mpeg_transport_mode(mode), .drop_null_en(drop_null), .ts_valid(ts_valid), .ts_data(ts_data),
    .ts_first(ts_first), .ts_last(ts_last), .pkt_ok(pkt_ok), .pkt_drop(pkt_drop), .session_teardown_message(td),
    .latency_probe(), .seq_gap(gap), .last_seq(last_seq));
  pw_node_rx u_pw_node_rx_bad (.core_clk(core_clk), .resetn(resetn), .link(bad), .session_identifier(sid),
    .mpeg_transport_mode(1'b1), .drop_null_en(1'b0), .ts_valid(), .ts_data(), .ts_first(), .ts_last(),
    .pkt_ok(), .pkt_drop(bad_drop), .session_teardown_message(), .latency_probe(bad_probe), .seq_gap(),
    .last_seq());
  pw_link_sva u_pw_link_sva (.core_clk(core_clk), .resetn(resetn), .valid(link.valid), .ready(link.ready),
    .data(link.data), .first(link.first), .last(link.last));
  always #4 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // monitor: one note per status pulse
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
    if ((pkt_ok | pkt_drop | td) === 1'b1) begin
      if (exp_q.size() == 0) check("extra status", 32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        check("status", {29'h0, pkt_ok, pkt_drop, td}, {29'h0, e[50:48]});
        check("bytes", nbytes, e[47:16]);
        check("seq_gap", gap, e[51]);
        if (e[50]) check("last_seq", last_seq, e[15:0]);
      end
      nbytes = 0;
    end
    if (ts_valid === 1'b1) begin
      nbytes++;
      check("ts_data", ts_data, exp_byte);
      check("ts_first", ts_first, exp_byte == `TS_FIRST_FWD);
      check("ts_last", ts_last, exp_byte == `TS_LEN - 8'd1);
      exp_byte = (exp_byte == `TS_LEN - 8'd1) ? `TS_FIRST_FWD : exp_byte + 8'd1;
    end
  end
  initial begin
    bad.valid = 1'b0;
    bad.data = 8'h00;
    bad.first = 1'b0;
    bad.last = 1'b0;
    repeat (12) @(posedge core_clk);
    #1 resetn = 1'b1;
    rng = xs(rng);
    seed = rng[15:0];
    seq_load = 1'b1;
    @(posedge core_clk);
    #1 seq_load = 1'b0;
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      ts_count = (i == 0) ? 4'h1 : (i == 1) ? 4'h7 : 4'(rng[7:0] % 7 + 1);
      null_sel = rng[9];
      drop_null = rng[10];
      tx_id = (i == 3) ? sid ^ 32'h0000_0100 : sid;
      mode = (i != 5);
      if (i == 3) e = {4'b0010, 48'h0};
      else if (i == 5) e = {4'b0001, 48'h0};
      else e = {lost, 3'b100, 32'((null_sel && drop_null) ? 0 : (`TS_LEN - `TS_FIRST_FWD) * ts_count), 16'(seed + i)};
      lost = (i == 3 || i == 5);
      exp_q.push_back(e);
      start = 1'b1;
      @(posedge core_clk);
      #1 start = 1'b0;
      for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge core_clk);
      check("busy", busy, 1'b0);
      repeat (6) @(posedge core_clk);
      #1;
    end
    check("pending", exp_q.size(), 0);
    // faulty sender: wrong version, then a latency probe header
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 200; i++) begin
        bad.valid = 1'b1;
        bad.first = (i == 0);
        bad.last = (i == 199);
        bad.data = (i == 1) ? ((j == 0) ? 8'h02 : 8'h03) : (i == 8 && j == 1) ? 8'h50 :
                   (i >= 4 && i < 8) ? sid[8 * (7 - i) +: 8] : 8'h00;
        @(posedge core_clk);
        #1;
      end
      bad.valid = 1'b0;
      bad.last = 1'b0;
      bad.data = 8'hff;
      e[1:0] = 2'b00;
      for (int k = 0; k < 8; k++) begin
        @(posedge core_clk);
        e[0] = e[0] | (bad_drop === 1'b1);
        e[1] = e[1] | (bad_probe === 1'b1);
      end
      check("bad version drop", e[0], j == 0);
      check("latency probe", e[1], j == 1);
    end
    complete_run();
  end
endmodule // l2tpv3_mpeg_pw_receiver_test
